/* inc/dpwm_pkg.sv */
// Notes on behaviour
// (RL1) Two independent drivers; each routable onto pin 14 or pin 15.
// (RL2) Each driver has an eight-bit counter as its waveform time base.
// (RL3) Counter clock is selectable: slow 100 kHz or fast 24 MHz tick.
// (RL4) Each selected tick adds a four-bit step; step sets output frequency.
// (RL5) Eight-bit threshold sets duty; output falls when count reaches it.
// (RL6) In sleep the fast clock stops; fast-clocked drivers are disabled.
// (RL7) Slow-clocked drivers keep running through sleep.
// (RL8) Counter wraps modulo 256; output high at wrap, low from threshold.
package dpwm_pkg;

    // ------------------------------------------------------------
    // Clock rates and tick generation
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int SLOW_CLK_HZ = 100_000;
    localparam int FAST_CLK_HZ = 24_000_000;
    localparam int RATE_UNIT_HZ = 1_000_000;
    localparam logic [7:0] SLOW_DIV_LAST =
        8'(SYS_CLK_HZ / SLOW_CLK_HZ - 1);
    localparam logic [4:0] FAST_ACC_STEP = 5'(FAST_CLK_HZ / RATE_UNIT_HZ);
    localparam logic [4:0] FAST_ACC_MOD = 5'(SYS_CLK_HZ / RATE_UNIT_HZ);
    localparam logic [7:0] SLOW_DIV_RST = 8'h00;
    localparam logic [4:0] FAST_ACC_RST = 5'h00;

    // ------------------------------------------------------------
    // Driver geometry
    // ------------------------------------------------------------
    localparam int NUM_CH = 2;
    localparam int CNT_W = 8;
    localparam int STEP_W = 4;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] THRESH_RST = 8'h00;
    localparam logic [STEP_W-1:0] STEP_RST = 4'h0;
    localparam logic PIN_SEL_LO = 1'b0;
    localparam logic PIN_SEL_HI = 1'b1;

    typedef enum logic {DPWM_SRC_SLOW, DPWM_SRC_FAST} dpwm_src_e;

    typedef struct packed {
        logic enable;
        dpwm_src_e src;
        logic [STEP_W-1:0] step;
        logic [CNT_W-1:0] thresh;
        logic route_en;
        logic route_pin;
    } dpwm_cfg_s;

    typedef struct packed {
        logic running;
        logic sleep_off;
        logic level;
        logic [CNT_W-1:0] count;
    } dpwm_stat_s;

endpackage

/* hw/dpwm_channel.sv */
`timescale 1ns/100ps
`default_nettype none
module dpwm_channel (
    input wire logic clk,
    input wire logic srst,
    input wire dpwm_pkg::dpwm_cfg_s cfg,
    input wire logic tick,
    input wire logic sleep,
    output dpwm_pkg::dpwm_stat_s stat,
    output logic wrap
);
    typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_SLEPT} dpwm_ch_e;

    dpwm_ch_e state_reg, state_next;
    logic [dpwm_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic [dpwm_pkg::CNT_W-1:0] thresh_reg, thresh_next;
    logic [dpwm_pkg::STEP_W-1:0] step_reg, step_next;
    logic level_reg, level_next;
    logic wrap_reg, wrap_next;
    logic fast_blocked;
    logic [dpwm_pkg::CNT_W:0] sum;

    assign fast_blocked = sleep &&
        (cfg.src == dpwm_pkg::DPWM_SRC_FAST); // [RL6]
    // One carry bit beyond the count marks the modulo-256 wrap
    assign sum = {1'b0, cnt_reg} + {5'h00, step_reg}; // [RL4]

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        thresh_next = thresh_reg;
        step_next = step_reg;
        level_next = level_reg;
        wrap_next = 1'b0;
        unique case (state_reg)
            CH_OFF, CH_SLEPT: begin
                if (!cfg.enable) begin
                    state_next = CH_OFF;
                end else if (fast_blocked) begin
                    state_next = CH_SLEPT; // [RL6]
                end else begin
                    // Restart cleanly from a fresh period
                    state_next = CH_RUN;
                    cnt_next = dpwm_pkg::CNT_RST;
                    step_next = cfg.step;
                    thresh_next = cfg.thresh;
                    level_next = (cfg.thresh != dpwm_pkg::CNT_RST);
                end
            end
            CH_RUN: begin
                if (!cfg.enable) begin
                    state_next = CH_OFF;
                    level_next = 1'b0;
                end else if (fast_blocked) begin
                    state_next = CH_SLEPT; // [RL6]
                    level_next = 1'b0;
                end else if (tick) begin // [RL3] [RL7]
                    cnt_next = sum[dpwm_pkg::CNT_W-1:0]; // [RL2] [RL4]
                    if (sum[dpwm_pkg::CNT_W]) begin
                        // Shadows load at wrap so a period never glitches
                        wrap_next = 1'b1; // [RL8]
                        step_next = cfg.step;
                        thresh_next = cfg.thresh;
                        level_next = sum[dpwm_pkg::CNT_W-1:0] < cfg.thresh;
                    end else begin
                        // Once low, stays low until the next wrap
                        level_next = level_reg &&
                            (sum[dpwm_pkg::CNT_W-1:0] < thresh_reg); // [RL5]
                    end
                end
            end
            default: begin
                state_next = CH_OFF;
                level_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= CH_OFF;
            cnt_reg <= dpwm_pkg::CNT_RST;
            thresh_reg <= dpwm_pkg::THRESH_RST;
            step_reg <= dpwm_pkg::STEP_RST;
            level_reg <= 1'b0;
            wrap_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            thresh_reg <= thresh_next;
            step_reg <= step_next;
            level_reg <= level_next;
            wrap_reg <= wrap_next;
        end
    end

    assign stat.running = (state_reg == CH_RUN);
    assign stat.sleep_off = (state_reg == CH_SLEPT);
    assign stat.level = level_reg;
    assign stat.count = cnt_reg;
    assign wrap = wrap_reg;
endmodule
`default_nettype wire

/* hw/dpwm_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dpwm_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic sleep,
    input wire dpwm_pkg::dpwm_cfg_s [dpwm_pkg::NUM_CH-1:0] cfg,
    output dpwm_pkg::dpwm_stat_s [dpwm_pkg::NUM_CH-1:0] stat,
    output logic [dpwm_pkg::NUM_CH-1:0] wrap,
    output logic fast_clk_on,
    output logic gpio14_out,
    output logic gpio14_oe,
    output logic gpio15_out,
    output logic gpio15_oe
);
    // ------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------
    logic [7:0] slow_div_reg, slow_div_next;
    logic slow_tick_reg, slow_tick_next;
    logic [4:0] fast_acc_reg, fast_acc_next;
    logic fast_tick_reg, fast_tick_next;
    logic fast_on_reg, fast_on_next;
    logic [5:0] fast_sum;

    assign fast_sum = {1'b0, fast_acc_reg} + {1'b0, dpwm_pkg::FAST_ACC_STEP};

    always_comb begin
        slow_div_next = slow_div_reg + 8'h01;
        slow_tick_next = 1'b0;
        if (slow_div_reg == dpwm_pkg::SLOW_DIV_LAST) begin
            slow_div_next = dpwm_pkg::SLOW_DIV_RST;
            slow_tick_next = 1'b1; // [RL3]
        end
        // Fractional divider: 24 ticks in every 25 system cycles
        fast_acc_next = fast_sum[4:0];
        fast_tick_next = 1'b0;
        if (fast_sum >= {1'b0, dpwm_pkg::FAST_ACC_MOD}) begin
            fast_acc_next = 5'(fast_sum - {1'b0, dpwm_pkg::FAST_ACC_MOD});
            fast_tick_next = 1'b1; // [RL3]
        end
        fast_on_next = !sleep;
        if (sleep) begin
            // Fast clock is gone in sleep; slow one keeps running
            fast_acc_next = dpwm_pkg::FAST_ACC_RST; // [RL6]
            fast_tick_next = 1'b0; // [RL6] [RL7]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            slow_div_reg <= dpwm_pkg::SLOW_DIV_RST;
            slow_tick_reg <= 1'b0;
            fast_acc_reg <= dpwm_pkg::FAST_ACC_RST;
            fast_tick_reg <= 1'b0;
            fast_on_reg <= 1'b0;
        end else begin
            slow_div_reg <= slow_div_next;
            slow_tick_reg <= slow_tick_next;
            fast_acc_reg <= fast_acc_next;
            fast_tick_reg <= fast_tick_next;
            fast_on_reg <= fast_on_next;
        end
    end

    assign fast_clk_on = fast_on_reg;

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    logic [dpwm_pkg::NUM_CH-1:0] ch_tick;

    for (genvar i = 0; i < dpwm_pkg::NUM_CH; i++) begin : g_ch
        assign ch_tick[i] = (cfg[i].src == dpwm_pkg::DPWM_SRC_FAST) ?
            fast_tick_reg : slow_tick_reg; // [RL3]
        dpwm_channel u_ch (
            .clk(clk),
            .srst(srst),
            .cfg(cfg[i]),
            .tick(ch_tick[i]),
            .sleep(sleep),
            .stat(stat[i]),
            .wrap(wrap[i])
        ); // [RL1]
    end

    // ------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------
    function automatic logic routes_to(input dpwm_pkg::dpwm_cfg_s c,
                                       input logic pin);
        routes_to = c.enable && c.route_en && (c.route_pin == pin);
    endfunction

    logic pin14_out_reg, pin14_out_next, pin14_oe_reg, pin14_oe_next;
    logic pin15_out_reg, pin15_out_next, pin15_oe_reg, pin15_oe_next;

    // Both drivers on one pin: driver 0 wins, driver 1 is not seen
    always_comb begin
        pin14_oe_next = 1'b1;
        pin15_oe_next = 1'b1;
        if (routes_to(cfg[0], dpwm_pkg::PIN_SEL_LO)) begin
            pin14_out_next = stat[0].level; // [RL1]
        end else if (routes_to(cfg[1], dpwm_pkg::PIN_SEL_LO)) begin
            pin14_out_next = stat[1].level; // [RL1]
        end else begin
            pin14_out_next = 1'b0;
            pin14_oe_next = 1'b0;
        end
        if (routes_to(cfg[0], dpwm_pkg::PIN_SEL_HI)) begin
            pin15_out_next = stat[0].level; // [RL1]
        end else if (routes_to(cfg[1], dpwm_pkg::PIN_SEL_HI)) begin
            pin15_out_next = stat[1].level; // [RL1]
        end else begin
            pin15_out_next = 1'b0;
            pin15_oe_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pin14_out_reg <= 1'b0;
            pin14_oe_reg <= 1'b0;
            pin15_out_reg <= 1'b0;
            pin15_oe_reg <= 1'b0;
        end else begin
            pin14_out_reg <= pin14_out_next;
            pin14_oe_reg <= pin14_oe_next;
            pin15_out_reg <= pin15_out_next;
            pin15_oe_reg <= pin15_oe_next;
        end
    end

    assign gpio14_out = pin14_out_reg;
    assign gpio14_oe = pin14_oe_reg;
    assign gpio15_out = pin15_out_reg;
    assign gpio15_oe = pin15_oe_reg;
endmodule
`default_nettype wire

/* verification/dpwm_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module dpwm_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic sleep,
    input wire dpwm_pkg::dpwm_cfg_s [dpwm_pkg::NUM_CH-1:0] cfg,
    input wire dpwm_pkg::dpwm_stat_s [dpwm_pkg::NUM_CH-1:0] stat,
    input wire logic [dpwm_pkg::NUM_CH-1:0] wrap,
    input wire logic fast_clk_on,
    input wire logic gpio14_out,
    input wire logic gpio14_oe,
    input wire logic gpio15_out,
    input wire logic gpio15_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    fast_lag_a: assert property (
        !$past(srst) |-> fast_clk_on == !$past(sleep))
        else $error("fast flag");
    sleep_off_a: assert property (
        (sleep && cfg[1].enable && cfg[1].src == dpwm_pkg::DPWM_SRC_FAST)[*3]
        |-> !stat[1].running && !stat[1].level) else $error("fast in sleep");
    slow_keep_a: assert property ($past(stat[0].running)
        && $stable(cfg[0]) && cfg[0].enable
        && cfg[0].src == dpwm_pkg::DPWM_SRC_SLOW |-> stat[0].running)
        else $error("slow channel stopped");
    wrap_once_a: assert property (
        wrap[0] |=> !wrap[0]) else $error("wrap too long");
    wrap_low_a: assert property (
        wrap[0] |-> stat[0].count < 8'h10) else $error("wrap count high");
    step_size_a: assert property (
        stat[0].running && $past(stat[0].running)
        |-> 8'(stat[0].count - $past(stat[0].count)) < 8'h10)
        else $error("count jump");
    rise_wrap_a: assert property (
        $rose(stat[0].level) && $past(stat[0].running) |-> wrap[0])
        else $error("rise off wrap");
    fall_thresh_a: assert property (
        $fell(stat[0].level) && stat[0].running && $stable(cfg[0])
        |-> stat[0].count >= cfg[0].thresh) else $error("early fall");
    pin_follow_a: assert property ($past(stat[0].running)
        && $past(cfg[0].enable) && $past(cfg[0].route_en)
        && !$past(cfg[0].route_pin)
        |-> gpio14_out == $past(stat[0].level)) else $error("pin data");
    pin_idle_a: assert property (
        (!cfg[0].enable && !cfg[1].enable)[*2] |-> !gpio14_oe && !gpio15_oe)
        else $error("pin driven idle");
    cover property (wrap[0]);
    cover property (sleep && stat[1].sleep_off);
    cover property ($fell(stat[0].level));
endmodule
bind dpwm_top dpwm_monitor u_dpwm_monitor (.clk(clk), .srst(srst),
    .sleep(sleep), .cfg(cfg), .stat(stat), .wrap(wrap),
    .fast_clk_on(fast_clk_on), .gpio14_out(gpio14_out),
    .gpio14_oe(gpio14_oe), .gpio15_out(gpio15_out), .gpio15_oe(gpio15_oe));
`default_nettype wire

/* verification/dpwm_load.sv */
`timescale 1ns/100ps
`default_nettype none
module dpwm_load (
    input wire logic clk,
    input wire logic pin,
    input wire logic oe,
    output var int period,
    output var int high_time
);
    int cnt = 0;
    int hi = 0;
    logic last = 1'b0;
    // Undriven pin reads low: the load has a pull-down
    wire logic lvl = pin && oe;
    always @(posedge clk) begin
        last <= lvl;
        cnt <= cnt + 1;
        hi <= hi + int'(lvl);
        if (lvl && !last) begin
            period <= cnt;
            high_time <= hi;
            cnt <= 1;
            hi <= 1;
        end
    end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk;
    logic srst;
    logic sleep;
    dpwm_pkg::dpwm_cfg_s [dpwm_pkg::NUM_CH-1:0] cfg;
    dpwm_pkg::dpwm_stat_s [dpwm_pkg::NUM_CH-1:0] stat;
    logic [1:0] wrap;
    logic fast_on, g14, g14_oe, g15, g15_oe;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    int p14, h14, p15, h15, n;
    dpwm_top u_dpwm_top (.clk(clk), .srst(srst), .sleep(sleep), .cfg(cfg),
        .stat(stat), .wrap(wrap), .fast_clk_on(fast_on),
        .gpio14_out(g14), .gpio14_oe(g14_oe),
        .gpio15_out(g15), .gpio15_oe(g15_oe));
    dpwm_load u_load14 (.clk(clk), .pin(g14), .oe(g14_oe),
        .period(p14), .high_time(h14));
    dpwm_load u_load15 (.clk(clk), .pin(g15), .oe(g15_oe),
        .period(p15), .high_time(h15));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic set_ch(input int i, input logic en, input logic fast,
        input logic [3:0] step, input logic [7:0] thr, input logic pin);
        @(negedge clk);
        cfg[i] = '{en, dpwm_pkg::dpwm_src_e'(fast), step, thr, 1'b1, pin};
    endtask
    task automatic wait_wrap(input int i);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wrap[i] !== 1'b1 && n < 9000);
        check("wrap seen", 32'(n < 9000), 1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Whole run is about 32k cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        srst = 1'b1;
        sleep = 1'b0;
        cfg = '0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check("stat", 32'(stat), 0);
        check("fast on", 32'(fast_on), 1);
        $display("test reset done");
        set_ch(0, 1'b1, 1'b0, 4'h8, 8'h40, 1'b0);
        set_ch(1, 1'b1, 1'b1, 4'h8, 8'h40, 1'b1);
        wait_wrap(0);
        wait_wrap(0);
        repeat (3) @(negedge clk);
        check("slow period", 32'(p14), 8000);
        check("slow high", 32'(h14), 2000);
        check("fast period", 32'(p15 inside {33, 34}), 1);
        check("fast high", 32'(h15 inside {8, 9}), 1);
        $display("test waveform done");
        sleep = 1'b1;
        repeat (4) @(negedge clk);
        check("fast run", 32'(stat[1].running), 0);
        check("fast off", 32'(stat[1].sleep_off), 1);
        check("pin15", 32'(g15), 0);
        check("fast on", 32'(fast_on), 0);
        wait_wrap(0);
        check("slow run", 32'(stat[0].running), 1);
        sleep = 1'b0;
        repeat (4) @(negedge clk);
        check("fast back", 32'(stat[1].running), 1);
        $display("test sleep done");
        set_ch(0, 1'b1, 1'b0, 4'h8, 8'h00, 1'b0);
        set_ch(1, 1'b1, 1'b1, 4'hF, 8'h80, 1'b0);
        wait_wrap(0);
        n = 0;
        repeat (200) @(negedge clk) n += int'(g14);
        check("pin14 highs", 32'(n), 0);
        check("pin15 oe", 32'(g15_oe), 0);
        set_ch(0, 1'b0, 1'b0, 4'h8, 8'h00, 1'b0);
        repeat (2) @(negedge clk);
        check("ch0 off", 32'(stat[0].running), 0);
        $display("test routing done");
        end_sim();
    end
endmodule
`default_nettype wire
